// *** crc8_byte.sv ***
/*
 * one byte step of the 8-bit checksum, msb first, no reflection.
 * assumes the caller registers the result.
 */
`timescale 1ns/1ps
module crc8_byte
	import i2c_port_pkg::*;
(
	// running value and new byte
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] crc_out
);

	logic [7:0] stage [0:8];

	assign stage[0] = crc_in ^ data_in;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_shift
			assign stage[gi+1] = stage[gi][7] ?
				({stage[gi][6:0], 1'b0} ^ CRC_POLY) :
				{stage[gi][6:0], 1'b0};
		end
	endgenerate

	assign crc_out = stage[8];

endmodule : crc8_byte

// *** i2c_host_model.sv ***
/*
 * behavioural i2c controller: drives scl and an open-drain sda.
 * assumes the bench resolves sda with a pull-up and feeds it back.
 */
`timescale 1ns/1ps
module i2c_host_model (
	// clock
	input  wire logic sys_clk,
	// bus
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_w
);
	// scl idles high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick

	// 80 ns bit; sda moves only while scl is low
	task automatic put_bit(input logic b, output logic got);
		tick(2);
		sda_o = b;
		tick(6);
		scl_o = 1'b1;
		tick(4);
		got = sda_w;
		tick(4);
		scl_o = 1'b0;
	endtask : put_bit

	task automatic start();
		tick(2);
		sda_o = 1'b1;
		tick(6);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b0;
	endtask : start

	task automatic stop();
		tick(2);
		sda_o = 1'b0;
		tick(6);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b1;
		tick(4);
	endtask : stop

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], g);
		put_bit(1'b1, g);
		ack = ~g;
	endtask : send_byte

	// ack every byte but the last, which gets a nack
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, g);
			d[i] = g;
		end
		put_bit(last, g);
	endtask : recv_byte
endmodule : i2c_host_model

// *** i2c_paged_control_port.sv ***
/*
 * i2c target control port with book/page register space and two
 * running checksums over write traffic.
 * assumes scl/sda arrive as open-drain levels resolved outside, the
 * strap code is decoded outside and static, and the external memory
 * answers mem_rdata within a few clocks of its address.
 */
`timescale 1ns/1ps
// Functional notes
// - works as target at 100 and 400 kHz, single and multi-byte.
// - answers 7-bit address 01011 followed by two strap bits.
// - strap bits 00..11 follow strap resistors 4.7k, 15k, 47k, 120k.
// - write: address, sub-address and each data byte are acknowledged.
// - each written byte advances sub-address by one as its ack is driven.
// - read: sub-address write, repeated start, address with read bit.
// - multi-byte read returns successive sub-addresses; controller acks.
// - writing register 0 on any page selects the page 0..255.
// - book changes only via register 0x7f while on page zero.
// - reads leave checksums alone; only writes update them.
// - crc and xor checksums run together, both readable on page zero, xor only in book 0x8c.
// - crc uses polynomial 0x07 and depends on byte order.
// - crc skips writes that switch book or page.
// - crc read at 0x7e page zero of any book; writing reseeds.
// - each checksum is reseeded by writing its own location.
// - xor folds each byte written in book 0x8c off page zero, except writes to register 0, into the running value.
// - xor covers book 0x8c only, not page switch nor page zero.
// - xor read at 0x7d page zero book 0x8c; writing reseeds.
module i2c_paged_control_port
	import i2c_port_pkg::*;
(
	// system
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// i2c pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// decoded strap code
	input  wire logic [1:0] strap_code,
	// register and memory space
	output logic            mem_wr_en,
	output logic [7:0]      mem_book,
	output logic [7:0]      mem_page,
	output logic [7:0]      mem_reg,
	output logic [7:0]      mem_wdata,
	input  wire logic [7:0] mem_rdata,
	// checksum and selection state
	output logic [7:0]      crc_value,
	output logic [7:0]      xor_value,
	output logic [7:0]      page_value,
	output logic [7:0]      book_value
);

	logic [3:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic [1:0]  strap_s;
	logic        scl_prev_q;
	logic        sda_prev_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	port_state_t state_q;
	logic [3:0]  cnt_q;
	logic [7:0]  shift_q;
	logic [7:0]  tx_q;
	logic        rw_q;
	logic        mack_q;
	logic        sda_oe_q;
	logic        sda_out_q;
	logic [1:0]  strap_q;
	logic        strap_done_q;
	logic [1:0]  strap_arm_q;
	logic [7:0]  sub_q;
	logic [7:0]  page_q;
	logic [7:0]  book_q;
	logic [7:0]  crc_q;
	logic [7:0]  xor_q;
	logic [7:0]  crc_next;
	logic [7:0]  rd_byte;
	logic        byte_done;
	logic        addr_hit;
	logic        rx_state;
	logic        wr_fire;
	logic        rd_step;
	logic        is_page;
	logic        is_book;
	logic        is_crc;
	logic        is_xor;
	logic        xor_span;
	logic        mem_wr_q;
	logic [7:0]  mem_book_q;
	logic [7:0]  mem_page_q;
	logic [7:0]  mem_reg_q;
	logic [7:0]  mem_wdata_q;

	// pins cross into sys_clk before any logic looks at them
	pin_sync #(
		.WIDTH(4)
	) u_sync (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.pin_in   ({strap_code, sda_in, scl_in}),
		.level_out(pins_s)
	);

	assign scl_s   = pins_s[0];
	assign sda_s   = pins_s[1];
	assign strap_s = pins_s[3:2];

	crc8_byte u_crc (
		.crc_in (crc_q),
		.data_in(shift_q),
		.crc_out(crc_next)
	);

	// 200 MHz oversampling leaves >60 samples per fast-mode half bit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// synchroniser still shows its reset ones for two edges after
	// release; capturing earlier would always latch strap code 11
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_arm_q <= 2'h0;
		end else begin
			strap_arm_q <= {strap_arm_q[0], 1'b1};
		end
	end

	// strap caught once, after the sync chain has flushed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_q      <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (strap_arm_q[1] && !strap_done_q) begin
			strap_q      <= strap_s;
			strap_done_q <= 1'b1;
		end
	end

	assign byte_done = (cnt_q == BYTE_BITS);
	assign addr_hit  = (shift_q[7:1] == {ADDR_PREFIX, strap_q});
	assign rx_state  = (state_q == ST_ADDR) || (state_q == ST_SUB) ||
		(state_q == ST_WDATA);
	assign wr_fire   = (state_q == ST_WDATA) && scl_fall && byte_done;
	assign rd_step   = (state_q == ST_RACK) && scl_rise && !sda_s;

	// register decode for the current sub-address
	assign is_page  = (sub_q == REG_PAGE);
	assign is_book  = (page_q == PAGE_ZERO) && (sub_q == REG_BOOK);
	assign is_crc   = (page_q == PAGE_ZERO) && (sub_q == REG_CRC);
	assign is_xor   = (book_q == BOOK_XOR) && (page_q == PAGE_ZERO) &&
		(sub_q == REG_XOR);
	assign xor_span = (book_q == BOOK_XOR) && (page_q != PAGE_ZERO) &&
		!is_page;

	always_comb begin
		if (is_page) begin
			rd_byte = page_q;
		end else if (is_book) begin
			rd_byte = book_q;
		end else if (is_crc) begin
			rd_byte = crc_q;
		end else if (is_xor) begin
			rd_byte = xor_q;
		end else begin
			rd_byte = mem_rdata;
		end
	end

	// bit counter and receive shifter
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q   <= CNT_ZERO;
			shift_q <= BYTE_RESET;
		end else if (start_det || stop_det) begin
			cnt_q <= CNT_ZERO;
		end else if (scl_rise) begin
			if (rx_state) begin
				shift_q <= {shift_q[6:0], sda_s};
			end
			if (rx_state || state_q == ST_RDATA) begin
				cnt_q <= cnt_q + CNT_ONE;
			end
		end else if (scl_fall && !rx_state && state_q != ST_RDATA) begin
			cnt_q <= CNT_ZERO;
		end
	end

	// protocol sequencing and sda drive; stop from controller ends all
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q  <= ST_IDLE;
			sda_oe_q <= 1'b0;
			tx_q     <= BYTE_RESET;
			rw_q     <= 1'b0;
			mack_q   <= 1'b0;
		end else if (stop_det) begin
			state_q  <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_det) begin
			state_q  <= ST_ADDR;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				ST_ADDR: begin
					if (scl_fall && byte_done) begin
						rw_q <= shift_q[0];
						if (addr_hit) begin
							state_q  <= ST_ADDR_ACK;
							sda_oe_q <= 1'b1;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							state_q  <= ST_RDATA;
							tx_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end else begin
							state_q  <= ST_SUB;
							sda_oe_q <= 1'b0;
						end
					end
				end
				ST_SUB: begin
					if (scl_fall && byte_done) begin
						state_q  <= ST_SUB_ACK;
						sda_oe_q <= 1'b1;
					end
				end
				ST_SUB_ACK: begin
					if (scl_fall) begin
						state_q  <= ST_WDATA;
						sda_oe_q <= 1'b0;
					end
				end
				ST_WDATA: begin
					if (scl_fall && byte_done) begin
						state_q  <= ST_WR_ACK;
						sda_oe_q <= 1'b1;
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						state_q  <= ST_WDATA;
						sda_oe_q <= 1'b0;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (byte_done) begin
							state_q  <= ST_RACK;
							sda_oe_q <= 1'b0;
						end else begin
							tx_q     <= {tx_q[6:0], 1'b0};
							sda_oe_q <= ~tx_q[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s;
					end
					if (scl_fall) begin
						if (mack_q) begin
							state_q  <= ST_RDATA;
							tx_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// open drain: the data level is always low, only the enable moves
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_out_q <= 1'b0;
		end else begin
			sda_out_q <= 1'b0;
		end
	end

	// sub-address pointer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sub_q <= BYTE_RESET;
		end else if (state_q == ST_SUB && scl_fall && byte_done) begin
			sub_q <= shift_q;
		end else if (wr_fire) begin
			sub_q <= sub_q + ADDR_STEP;
		end else if (rd_step) begin
			sub_q <= sub_q + ADDR_STEP;
		end
	end

	// page and book selection
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			page_q <= BYTE_RESET;
			book_q <= BYTE_RESET;
		end else if (wr_fire) begin
			if (is_page) begin
				page_q <= shift_q;
			end
			if (is_book) begin
				book_q <= shift_q;
			end
		end
	end

	// checksums move only on a write strobe, never on reads
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			crc_q <= BYTE_RESET;
		end else if (wr_fire) begin
			if (is_crc) begin
				crc_q <= shift_q;
			end else if (!is_page && !is_book) begin
				crc_q <= crc_next;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			xor_q <= BYTE_RESET;
		end else if (wr_fire) begin
			if (is_xor) begin
				xor_q <= shift_q;
			end else if (xor_span) begin
				xor_q <= xor_q ^ shift_q;
			end
		end
	end

	// memory side; captured on the strobe edge, before pointer moves
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_wr_q    <= 1'b0;
			mem_book_q  <= BYTE_RESET;
			mem_page_q  <= BYTE_RESET;
			mem_reg_q   <= BYTE_RESET;
			mem_wdata_q <= BYTE_RESET;
		end else begin
			mem_wr_q   <= wr_fire;
			mem_book_q <= book_q;
			mem_page_q <= page_q;
			mem_reg_q  <= sub_q;
			if (wr_fire) begin
				mem_wdata_q <= shift_q;
			end
		end
	end

	assign sda_out    = sda_out_q;
	assign sda_oe     = sda_oe_q;
	assign mem_wr_en  = mem_wr_q;
	assign mem_book   = mem_book_q;
	assign mem_page   = mem_page_q;
	assign mem_reg    = mem_reg_q;
	assign mem_wdata  = mem_wdata_q;
	assign crc_value  = crc_q;
	assign xor_value  = xor_q;
	assign page_value = page_q;
	assign book_value = book_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_addr_miss_quiet: assert property (
		state_q == ST_ADDR && scl_fall && byte_done && !addr_hit
		|=> !sda_oe_q && state_q == ST_IDLE)
		else $error("foreign address was acknowledged");

	a_addr_hit_ack: assert property (
		state_q == ST_ADDR && scl_fall && byte_done && addr_hit
		|=> sda_oe_q && state_q == ST_ADDR_ACK)
		else $error("own address not acknowledged");

	a_sub_byte_ack: assert property (
		state_q == ST_SUB && scl_fall && byte_done
		|=> sda_oe_q ##1 sda_oe_q)
		else $error("sub-address byte not acknowledged");

	a_write_advance: assert property (
		wr_fire |=> sub_q == 8'($past(sub_q) + ADDR_STEP))
		else $error("sub-address did not advance after write");

	a_read_advance: assert property (
		rd_step |=> sub_q == 8'($past(sub_q) + ADDR_STEP))
		else $error("sub-address did not advance after acked read");

	a_page_select: assert property (
		wr_fire && is_page |=> page_q == $past(shift_q))
		else $error("page select write lost");

	a_book_guard: assert property (
		wr_fire && sub_q == REG_BOOK && page_q != PAGE_ZERO
		|=> book_q == $past(book_q))
		else $error("book changed off page zero");

	a_sums_idle_hold: assert property (
		!wr_fire |=> $stable(crc_q) && $stable(xor_q))
		else $error("checksum moved without a write");

	a_crc_step: assert property (
		wr_fire && !is_page && !is_book && !is_crc
		|=> crc_q == $past(crc_next))
		else $error("crc did not fold written byte");

	a_xor_step: assert property (
		wr_fire && book_q != BOOK_XOR |=> xor_q == $past(xor_q))
		else $error("xor moved outside its book");

	a_xor_fold: assert property (
		wr_fire && xor_span && !is_xor
		|=> xor_q == ($past(xor_q) ^ $past(shift_q)))
		else $error("xor did not fold written byte");

	c_write_byte: cover property (wr_fire ##[1:1000] wr_fire);
	c_read_next: cover property (rd_step);
	c_crc_seed: cover property (wr_fire && is_crc);
	c_xor_fold: cover property (wr_fire && xor_span);

endmodule : i2c_paged_control_port

// *** i2c_paged_control_port_tb_top.sv ***
/*
 * self-checking bench of the paged i2c control port.
 * assumes the host model above and a pull-up on sda.
 */
`timescale 1ns/1ps
module i2c_paged_control_port_tb_top
	import i2c_port_pkg::*;
;
	typedef struct packed {
		logic [7:0] sub;
		logic [7:0] dat;
		logic [7:0] pg;
		logic [7:0] bk;
	} row_t;

	logic        sys_clk, reset_n, scl_o, sda_o, sda_w;
	logic        sda_out, sda_oe, mem_wr_en;
	logic [1:0]  strap;
	logic [7:0]  mem_book, mem_page, mem_reg, mem_wdata, mem_rdata;
	logic [7:0]  crc_value, xor_value, page_value, book_value;
	logic [7:0]  page_s, book_s, crc_s, xor_s;
	logic [31:0] wlog[$];
	logic [31:0] wexp[$];
	int          n_errors = 0;
	int          checks = 0;
	int          n0;
	logic        ack;
	row_t rows[13] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h7f, 8'h8c, 8'h00, 8'h8c},
		'{8'h00, 8'h2a, 8'h2a, 8'h8c}, '{8'h24, 8'h80, 8'h2a, 8'h8c},
		'{8'h25, 8'h11, 8'h2a, 8'h8c}, '{8'h00, 8'h00, 8'h00, 8'h8c},
		'{8'h7d, 8'h00, 8'h00, 8'h8c}, '{8'h7e, 8'h00, 8'h00, 8'h8c},
		'{8'h10, 8'h55, 8'h00, 8'h8c}, '{8'h7f, 8'haa, 8'h00, 8'haa},
		'{8'h00, 8'h05, 8'h05, 8'haa}, '{8'h7f, 8'h33, 8'h05, 8'haa},
		'{8'h40, 8'hc3, 8'h05, 8'haa}};

	// sda: open drain, released lines float high
	assign sda_w = sda_o & (sda_oe ? sda_out : 1'b1);

	i2c_host_model i2c_host_model_inst (
		.sys_clk(sys_clk), .scl_o(scl_o), .sda_o(sda_o), .sda_w(sda_w));

	i2c_paged_control_port i2c_paged_control_port_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_o),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.strap_code(strap), .mem_wr_en(mem_wr_en), .mem_book(mem_book),
		.mem_page(mem_page), .mem_reg(mem_reg), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .crc_value(crc_value),
		.xor_value(xor_value), .page_value(page_value),
		.book_value(book_value));

	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;

	// memory answers a pattern of its address
	always @(negedge sys_clk)
		mem_rdata <= mem_reg ^ mem_page ^ 8'h5a;
	always @(posedge sys_clk)
		if (mem_wr_en === 1'b1)
			wlog.push_back({mem_book, mem_page, mem_reg, mem_wdata});

	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		return r;
	endfunction : crc_step

	function automatic logic [7:0] exp_rd(logic [7:0] r);
		if (r == REG_PAGE)
			return page_s;
		if (page_s == PAGE_ZERO && r == REG_BOOK)
			return book_s;
		if (page_s == PAGE_ZERO && r == REG_CRC)
			return crc_s;
		if (page_s == PAGE_ZERO && book_s == BOOK_XOR && r == REG_XOR)
			return xor_s;
		return r ^ page_s ^ 8'h5a;
	endfunction : exp_rd

	// effect of one written byte on page, book and checksums
	task automatic apply_wr(input logic [7:0] sub, input logic [7:0] d);
		logic p0;
		p0 = (page_s == PAGE_ZERO);
		if (sub == REG_PAGE)
			page_s = d;
		else if (sub == REG_BOOK && p0)
			book_s = d;
		else if (sub == REG_CRC && p0)
			crc_s = d;
		else
			crc_s = crc_step(crc_s, d);
		if (book_s == BOOK_XOR && p0 && sub == REG_XOR)
			xor_s = d;
		else if (book_s == BOOK_XOR && !p0 && sub != REG_PAGE)
			xor_s = xor_s ^ d;
	endtask : apply_wr

	task automatic state_ok(input string msg);
		check({page_value, book_value, crc_value, xor_value} ===
			{page_s, book_s, crc_s, xor_s}, msg);
	endtask : state_ok

	task automatic adr(input logic [7:0] a, input logic exp);
		i2c_host_model_inst.start();
		i2c_host_model_inst.send_byte(a, ack);
		check(ack === exp, "address ack");
	endtask : adr

	// memory slots carry book and page as they stood before the byte
	task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
		n0 = wlog.size();
		wexp.delete();
		adr({ADDR_PREFIX, strap, 1'b0}, 1'b1);
		i2c_host_model_inst.send_byte(sub, ack);
		check(ack === 1'b1, "sub ack");
		foreach (d[i]) begin
			i2c_host_model_inst.send_byte(d[i], ack);
			check(ack === 1'b1, "data ack");
			wexp.push_back({book_s, page_s, sub + 8'(i), d[i]});
			apply_wr(sub + 8'(i), d[i]);
		end
		i2c_host_model_inst.stop();
		check(wlog.size() == n0 + d.size(), "write count");
		foreach (wexp[i])
			check(wlog[n0 + i] === wexp[i], "write slot");
		state_ok("state after write");
	endtask : wr

	task automatic rd(input logic [7:0] sub, input int n);
		logic [7:0] d;
		n0 = wlog.size();
		adr({ADDR_PREFIX, strap, 1'b0}, 1'b1);
		i2c_host_model_inst.send_byte(sub, ack);
		adr({ADDR_PREFIX, strap, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			i2c_host_model_inst.recv_byte(i == n - 1, d);
			check(d === exp_rd(sub + 8'(i)), "read data");
		end
		i2c_host_model_inst.stop();
		check(wlog.size() == n0, "read wrote");
		state_ok("state after read");
	endtask : rd

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		reset_n = 1'b1;
		{page_s, book_s, crc_s, xor_s} = 32'h0000_0000;
		repeat (6) @(negedge sys_clk);
	endtask : do_reset

	initial begin
		#400_000;
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		reset_n = 1'b0;
		strap = 2'b00;
		for (int s = 0; s < 4; s++) begin
			strap = 2'(s);
			do_reset();
			state_ok("reset values");
			adr({ADDR_PREFIX, strap ^ 2'b01, 1'b0}, 1'b0);
			i2c_host_model_inst.stop();
			adr({ADDR_PREFIX ^ 5'h10, strap, 1'b0}, 1'b0);
			i2c_host_model_inst.stop();
			wr(8'h7e, '{8'h00});
		end
		$display("test address done");
		do_reset();
		foreach (rows[i]) begin
			wr(rows[i].sub, '{rows[i].dat});
			check({page_value, book_value} ===
				{rows[i].pg, rows[i].bk}, "row select");
		end
		// one biquad: five coefficients, ascending, in one burst
		wr(8'h48, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
		$display("test rows done");
		wr(8'h00, '{8'h00});
		wr(8'h7f, '{8'h8c});
		wr(8'h00, '{8'h2a});
		wr(8'h7e, '{8'h01, 8'h02, 8'h03});
		wr(8'hff, '{8'h44, 8'h00});
		$display("test burst write done");
		rd(8'h7d, 3);
		rd(8'hff, 2);
		rd(8'h24, 1);
		$display("test read done");
		conclude();
	end
endmodule : i2c_paged_control_port_tb_top

// *** i2c_port_pkg.sv ***
/*
 * shared constants and state encoding of the paged i2c control port.
 * assumes a single 200 MHz system clock domain.
 */
package i2c_port_pkg;

	// clock and bus timing
	localparam int unsigned SYS_CLK_MHZ  = 200;
	localparam int unsigned I2C_FAST_KHZ = 400;
	localparam int unsigned SCL_MIN_CYC  =
		(SYS_CLK_MHZ * 1000) / (2 * I2C_FAST_KHZ);

	// target address
	localparam logic [4:0] ADDR_PREFIX = 5'h0b;
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [3:0] CNT_ZERO    = 4'h0;
	localparam logic [3:0] CNT_ONE     = 4'h1;

	// register offsets
	localparam logic [7:0] REG_PAGE = 8'h00;
	localparam logic [7:0] REG_XOR  = 8'h7d;
	localparam logic [7:0] REG_CRC  = 8'h7e;
	localparam logic [7:0] REG_BOOK = 8'h7f;

	// books, pages and reset values
	localparam logic [7:0] PAGE_ZERO  = 8'h00;
	localparam logic [7:0] BOOK_XOR   = 8'h8c;
	localparam logic [7:0] BOOK_BQ    = 8'haa;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] ADDR_STEP  = 8'h01;

	// checksum generator x^8 + x^2 + x + 1
	localparam logic [7:0] CRC_POLY = 8'h07;

	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_ADDR     = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_SUB      = 9'h008,
		ST_SUB_ACK  = 9'h010,
		ST_WDATA    = 9'h020,
		ST_WR_ACK   = 9'h040,
		ST_RDATA    = 9'h080,
		ST_RACK     = 9'h100
	} port_state_t;

endpackage : i2c_port_pkg

// *** pin_sync.sv ***
/*
 * two-flop synchroniser for a group of asynchronous pin levels.
 * assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// pins in, levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] level_q;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			// first flop idles high like a released bus line
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					meta_q[gi]  <= 1'b1;
					level_q[gi] <= 1'b1;
				end else begin
					meta_q[gi]  <= pin_in[gi];
					level_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign level_out = level_q;

endmodule : pin_sync
